/* File: rtl/gpmc_pkg.sv */
// package with constants and types for the gauge power mode controller
package gpmc_pkg;
   // clock rate and derived half-second tick
   localparam int unsigned CLK_HZ          = 50000000;          // core clock in hertz
   localparam int unsigned HALF_SEC_MS     = 500;               // accumulation period in ms
   localparam int unsigned HALF_SEC_CYC    = CLK_HZ / 1000 * HALF_SEC_MS; // cycles per half second
   // bus line timings (values not given elsewhere, plain defaults)
   localparam int unsigned STORAGE_ENTRY_US = 2000;             // storage entry low time in us
   localparam int unsigned WAKE_US          = 1000;             // wake high time in us
   localparam int unsigned STORAGE_ENTRY_CYC = (CLK_HZ / 1000000) * STORAGE_ENTRY_US; // least, exact
   localparam int unsigned WAKE_CYC          = (CLK_HZ / 1000000) * WAKE_US;          // least, exact
   // initialisation length in cycles
   localparam int unsigned INIT_CYC        = 16;                // nonvolatile load duration
   // reset values of the control bits
   localparam logic [2:0]  RATE_EXP_RST    = 3'h0;              // rate exponent after reset
   localparam logic [2:0]  SLEEP_EXP_RST   = 3'h0;              // sleep divider exponent after reset
   // wishbone register byte offsets
   localparam logic [7:0]  OFS_MODE_CTRL   = 8'h00;             // operating_mode_register
   localparam logic [7:0]  OFS_CONV_CFG    = 8'h04;             // converter_config_register
   localparam logic [7:0]  OFS_TRIP_CTRL   = 8'h08;             // trip enables
   localparam logic [7:0]  OFS_STATUS      = 8'h0c;             // mode status
   // field positions in the mode control register
   localparam int unsigned MC_SLEEP_REQ    = 0;                 // timed_sleep_request
   localparam int unsigned MC_STORAGE_REQ  = 1;                 // host storage sleep bit
   localparam int unsigned MC_SLEEP_EXP    = 4;                 // sleep_interval_exponent lsb
   // field positions in the converter config register
   localparam int unsigned CC_RATE_EN      = 0;                 // reduced-rate enable
   localparam int unsigned CC_RATE_EXP     = 4;                 // rate_interval_exponent lsb
   localparam int unsigned CC_NCONV        = 8;                 // conversions per cycle minus one
   // field positions in the trip control register
   localparam int unsigned TC_CELL_ENT     = 0;                 // low_cell_sleep_enable
   localparam int unsigned TC_AUX_ENT      = 1;                 // low_aux_sleep_enable
   localparam int unsigned TC_CUR_ENT      = 2;                 // low current sleep enable
   localparam int unsigned TC_CUR_WAKE     = 3;                 // charge current wake enable
   localparam int unsigned TC_VOLT_WAKE    = 4;                 // voltage_wake_enable
   localparam int unsigned TC_AUTO_STORE   = 5;                 // automatic storage sleep enable

   // operating modes
   typedef enum logic [2:0] {
      GPMC_RESET, GPMC_INIT, GPMC_RUN, GPMC_RATE, GPMC_TSLEEP, GPMC_STORE
   } gpmc_mode_t;

   // comparison results presented by the analog front end
   typedef struct packed {
      logic above_por;        // pack_voltage_input above power-on threshold
      logic cell_low;         // pack voltage below low_voltage_trip_level
      logic aux_low;          // aux_analog_input below low_voltage_trip_level
      logic current_low;      // current magnitude below low-current trip
      logic charge_high;      // charge current above charge trip
      logic volt_wake;        // pack voltage above voltage_wake_trip_level
      logic storage_low;      // pack voltage below storage_trip_level
   } gpmc_trips_t;
endpackage : gpmc_pkg

/* File: rtl/gpmc_ctrl.sv */
// power mode controller for the gauge, with wishbone control registers
// Behaviour
// - hold reset below threshold, load defaults, run
// - run mode converts cycle after cycle
// - accumulate every half second with latest results
// - stay in run without other modes
// - reduced-rate bit selects reduced-rate mode
// - reduced-rate interval half second times power two
// - accumulation continues at half second rate
// - timed sleep: analog off, one conversion set
// - enter timed sleep by request or trips
// - sleep interval uses both exponents
// - leave timed sleep by clear or wake
// - storage sleep: nothing runs, bus ignored
// - arm storage by host bit or auto
// - enter storage after lines low long enough
// - leave storage after lines high long enough
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module gpmc_ctrl #(
   parameter int unsigned HALF_CYC  = gpmc_pkg::HALF_SEC_CYC,      // cycles per half second
   parameter int unsigned ENTRY_CYC = gpmc_pkg::STORAGE_ENTRY_CYC, // storage entry low time
   parameter int unsigned WAKE_CYC  = gpmc_pkg::WAKE_CYC,          // wake high time
   parameter int unsigned INIT_CYC  = gpmc_pkg::INIT_CYC           // initialisation time
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // classic wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   // analog comparisons and bus lines
   input  wire gpmc_pkg::gpmc_trips_t trips_i,
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   // nonvolatile load handshake and power controls
   output logic                    nv_load_o,
   output logic                    conv_start_o,
   output logic                    accum_tick_o,
   output logic                    analog_on_o,
   output logic                    lp_osc_on_o,
   output logic                    bus_ignore_o,
   output logic [2:0]              mode_o
);
   // state and counters
   gpmc_pkg::gpmc_mode_t mode_reg;       // current operating mode
   logic [31:0]          half_cnt_reg;   // half-second divider
   logic [31:0]          line_cnt_reg;   // bus line dwell counter
   logic [31:0]          init_cnt_reg;   // initialisation counter
   logic [14:0]          per_cnt_reg;    // half-second ticks since the last conversion set
   logic [3:0]           conv_left_reg;  // conversions left in the current cycle
   logic                 half_tick;      // one-cycle half-second strobe
   // control registers
   logic                 sleep_req_reg;  // timed_sleep_request
   logic                 store_req_reg;  // host storage sleep bit
   logic [2:0]           sleep_exp_reg;  // sleep_interval_exponent
   logic                 rate_en_reg;    // reduced-rate enable
   logic [2:0]           rate_exp_reg;   // rate_interval_exponent
   logic [2:0]           nconv_reg;      // conversions per cycle minus one
   logic [5:0]           trip_en_reg;    // trip enables
   logic                 wb_req;         // new bus access this cycle
   logic                 sleep_want;     // timed sleep condition
   logic                 wake_want;      // timed sleep wake condition
   logic                 store_armed;    // storage sleep armed
   logic                 both_low;       // bus lines both low
   logic                 both_high;      // bus lines both high
   logic [14:0]          period;         // interval in half seconds
   logic                 set_start;      // a measurement set starts at this tick

   // interval in half-second units: two raised to an exponent sum
   function automatic logic [14:0] gpmc_pow2(input logic [3:0] e);
      gpmc_pow2 = 15'h0001 << e;
   endfunction : gpmc_pow2

   // mode condition decoding
   // the mode terms close the bus in the very cycle storage sleep begins
   assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~bus_ignore_o
                      & (mode_reg != gpmc_pkg::GPMC_STORE) & (mode_reg != gpmc_pkg::GPMC_RESET);
   assign sleep_want  = sleep_req_reg
                      | (trip_en_reg[gpmc_pkg::TC_CELL_ENT] & trips_i.cell_low)
                      | (trip_en_reg[gpmc_pkg::TC_AUX_ENT] & trips_i.aux_low)
                      | (trip_en_reg[gpmc_pkg::TC_CUR_ENT] & trips_i.current_low);
   assign wake_want   = (trip_en_reg[gpmc_pkg::TC_CUR_WAKE] & trips_i.charge_high)
                      | (trip_en_reg[gpmc_pkg::TC_VOLT_WAKE] & trips_i.volt_wake);
   assign store_armed = store_req_reg
                      | (trip_en_reg[gpmc_pkg::TC_AUTO_STORE] & trips_i.storage_low);
   assign both_low    = ~scl_i & ~sda_i;
   assign both_high   = scl_i & sda_i;
   // reduced rate uses one exponent, timed sleep adds the divider exponent
   assign period      = (mode_reg == gpmc_pkg::GPMC_TSLEEP)
                      ? gpmc_pow2({1'b0, rate_exp_reg} + {1'b0, sleep_exp_reg})
                      : gpmc_pow2({1'b0, rate_exp_reg});
   // no half-second strobe while storage sleep, reset or init hold the divider
   assign half_tick   = (half_cnt_reg == HALF_CYC - 1)
                      && (mode_reg == gpmc_pkg::GPMC_RUN || mode_reg == gpmc_pkg::GPMC_RATE
                          || mode_reg == gpmc_pkg::GPMC_TSLEEP);
   // a new set is due on the tick that closes the interval
   assign set_start   = half_tick && (per_cnt_reg >= period - 15'h1);

   // mode state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= gpmc_pkg::GPMC_RESET;
      end else if (!trips_i.above_por) begin
         mode_reg <= gpmc_pkg::GPMC_RESET;
      end else begin
         case (mode_reg)
            gpmc_pkg::GPMC_RESET: begin
               mode_reg <= gpmc_pkg::GPMC_INIT;
            end
            gpmc_pkg::GPMC_INIT: begin
               // defaults loaded, go to run
               if (init_cnt_reg == INIT_CYC - 1) begin
                  mode_reg <= gpmc_pkg::GPMC_RUN;
               end
            end
            gpmc_pkg::GPMC_STORE: begin
               // wake needs both lines high for the wake time
               if (both_high && line_cnt_reg >= WAKE_CYC - 1) begin
                  mode_reg <= gpmc_pkg::GPMC_INIT;
               end
            end
            gpmc_pkg::GPMC_TSLEEP: begin
               if (store_armed && both_low && line_cnt_reg >= ENTRY_CYC - 1) begin
                  mode_reg <= gpmc_pkg::GPMC_STORE;
               end else if (!sleep_want || wake_want) begin
                  // a trip that still holds keeps the device asleep unless a wake condition is seen
                  mode_reg <= gpmc_pkg::GPMC_RUN;
               end
            end
            default: begin
               // run and reduced rate share the priority ladder
               if (store_armed && both_low && line_cnt_reg >= ENTRY_CYC - 1) begin
                  mode_reg <= gpmc_pkg::GPMC_STORE;
               end else if (sleep_want && !wake_want) begin
                  mode_reg <= gpmc_pkg::GPMC_TSLEEP;
               end else if (rate_en_reg) begin
                  mode_reg <= gpmc_pkg::GPMC_RATE;
               end else begin
                  mode_reg <= gpmc_pkg::GPMC_RUN;
               end
            end
         endcase
      end
   end

   // initialisation counter and nonvolatile load strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_reg != gpmc_pkg::GPMC_INIT) begin
         init_cnt_reg <= 32'h0;
      end else begin
         init_cnt_reg <= init_cnt_reg + 32'h1;
      end
   end

   // bus line dwell counter restarts whenever the watched level breaks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_cnt_reg <= 32'h0;
      end else if ((mode_reg == gpmc_pkg::GPMC_STORE) ? !both_high : !both_low) begin
         line_cnt_reg <= 32'h0;
      end else if (line_cnt_reg != 32'hffffffff) begin
         line_cnt_reg <= line_cnt_reg + 32'h1;
      end
   end

   // half-second divider, stopped in storage sleep and reset
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_reg == gpmc_pkg::GPMC_STORE || mode_reg == gpmc_pkg::GPMC_RESET
          || mode_reg == gpmc_pkg::GPMC_INIT) begin
         half_cnt_reg <= 32'h0;
      end else if (half_tick) begin
         half_cnt_reg <= 32'h0;
      end else begin
         half_cnt_reg <= half_cnt_reg + 32'h1;
      end
   end

   // accumulation strobe on every half second in run, reduced-rate and timed sleep
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_tick_o <= 1'b0;
      end else begin
         accum_tick_o <= half_tick;
      end
   end

   // conversion scheduling: back to back in run, per interval otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_reg == gpmc_pkg::GPMC_STORE || mode_reg == gpmc_pkg::GPMC_RESET
          || mode_reg == gpmc_pkg::GPMC_INIT) begin
         conv_left_reg <= 4'h0;
         per_cnt_reg   <= 15'h0;
         conv_start_o  <= 1'b0;
      end else if (mode_reg == gpmc_pkg::GPMC_RUN) begin
         conv_start_o <= 1'b1;
         conv_left_reg <= (conv_left_reg == 4'h0) ? {1'b0, nconv_reg} : conv_left_reg - 4'h1;
         per_cnt_reg <= 15'h0;
      end else if (conv_left_reg != 4'h0) begin
         conv_start_o  <= 1'b1;
         conv_left_reg <= conv_left_reg - 4'h1;
      end else if (set_start) begin
         conv_start_o  <= 1'b1;
         conv_left_reg <= {1'b0, nconv_reg};
         per_cnt_reg   <= 15'h0;
      end else begin
         conv_start_o <= 1'b0;
         if (half_tick) begin
            per_cnt_reg <= per_cnt_reg + 15'h1;
         end
      end
   end

   // power control outputs follow the mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv_load_o    <= 1'b0;
         analog_on_o  <= 1'b0;
         lp_osc_on_o  <= 1'b0;
         bus_ignore_o <= 1'b1;
         mode_o       <= 3'h0;
      end else begin
         nv_load_o    <= (mode_reg == gpmc_pkg::GPMC_INIT);
         analog_on_o  <= (mode_reg == gpmc_pkg::GPMC_RUN) || (mode_reg == gpmc_pkg::GPMC_RATE)
                       || (conv_left_reg != 4'h0) || set_start;
         lp_osc_on_o  <= (mode_reg == gpmc_pkg::GPMC_TSLEEP);
         bus_ignore_o <= (mode_reg == gpmc_pkg::GPMC_STORE) || (mode_reg == gpmc_pkg::GPMC_RESET);
         mode_o       <= mode_reg;
      end
   end

   // control register writes; storage and init reload defaults
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_reg == gpmc_pkg::GPMC_INIT || mode_reg == gpmc_pkg::GPMC_STORE) begin
         sleep_req_reg <= 1'b0;
         store_req_reg <= 1'b0;
         sleep_exp_reg <= gpmc_pkg::SLEEP_EXP_RST;
         rate_en_reg   <= 1'b0;
         rate_exp_reg  <= gpmc_pkg::RATE_EXP_RST;
         nconv_reg     <= 3'h0;
         trip_en_reg   <= 6'h00;
      end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == gpmc_pkg::OFS_MODE_CTRL) begin
            sleep_req_reg <= wb_dat_i[gpmc_pkg::MC_SLEEP_REQ];
            store_req_reg <= wb_dat_i[gpmc_pkg::MC_STORAGE_REQ];
            sleep_exp_reg <= wb_dat_i[gpmc_pkg::MC_SLEEP_EXP +: 3];
         end else if (wb_adr_i == gpmc_pkg::OFS_CONV_CFG) begin
            rate_en_reg  <= wb_dat_i[gpmc_pkg::CC_RATE_EN];
            rate_exp_reg <= wb_dat_i[gpmc_pkg::CC_RATE_EXP +: 3];
         end else if (wb_adr_i == gpmc_pkg::OFS_TRIP_CTRL) begin
            trip_en_reg <= wb_dat_i[5:0];
         end
      end else if (wb_req && wb_we_i && wb_sel_i[1] && wb_adr_i == gpmc_pkg::OFS_CONV_CFG) begin
         nconv_reg <= wb_dat_i[gpmc_pkg::CC_NCONV +: 3];
      end
   end

   // wishbone answer: one-cycle ack, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (!wb_req) begin
            wb_dat_o <= 32'h0;
         end else if (wb_adr_i == gpmc_pkg::OFS_MODE_CTRL) begin
            wb_dat_o <= {25'h0, sleep_exp_reg, 2'h0, store_req_reg, sleep_req_reg};
         end else if (wb_adr_i == gpmc_pkg::OFS_CONV_CFG) begin
            wb_dat_o <= {21'h0, nconv_reg, 1'b0, rate_exp_reg, 3'h0, rate_en_reg};
         end else if (wb_adr_i == gpmc_pkg::OFS_TRIP_CTRL) begin
            wb_dat_o <= {26'h0, trip_en_reg};
         end else if (wb_adr_i == gpmc_pkg::OFS_STATUS) begin
            wb_dat_o <= {29'h0, mode_reg};
         end else begin
            wb_dat_o <= 32'h0;
         end
      end
   end

   // wake from storage only after the full high dwell
   chk_store_wake_dwell: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(mode_reg) == gpmc_pkg::GPMC_STORE && mode_reg == gpmc_pkg::GPMC_INIT)
      |-> $past(line_cnt_reg) >= WAKE_CYC - 1)
      else $error("left storage sleep too early");
   // storage entry needs arming
   chk_store_entry_arm: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_reg != gpmc_pkg::GPMC_STORE ##1 mode_reg == gpmc_pkg::GPMC_STORE)
      |-> $past(store_armed) && $past(both_low))
      else $error("storage sleep entered unarmed");
   // bus is ignored in storage sleep
   chk_store_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_reg == gpmc_pkg::GPMC_STORE)[*2] |-> !wb_ack_o && !accum_tick_o)
      else $error("activity in storage sleep");
   // below threshold the device falls to reset
   chk_por_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !trips_i.above_por |=> mode_reg == gpmc_pkg::GPMC_RESET)
      else $error("not held in reset below threshold");
   // run mode converts every cycle
   chk_run_convert: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == gpmc_pkg::GPMC_RUN && trips_i.above_por |=> conv_start_o)
      else $error("run mode idle");
   // accumulation strobe follows the half-second divider
   chk_accum_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      half_tick |=> accum_tick_o ##1 !accum_tick_o)
      else $error("half-second strobe wrong");
   // reduced-rate mode left when the bit is cleared
   chk_rate_exit: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == gpmc_pkg::GPMC_RATE && !rate_en_reg && !sleep_want && !store_armed
      && trips_i.above_por |=> mode_reg == gpmc_pkg::GPMC_RUN)
      else $error("reduced-rate not left");
   // timed sleep left on request clear
   chk_sleep_exit: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == gpmc_pkg::GPMC_TSLEEP && !sleep_want && !store_armed && trips_i.above_por
      |=> mode_reg == gpmc_pkg::GPMC_RUN)
      else $error("timed sleep not left");
   // storage exit reloads defaults
   chk_reinit: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(mode_reg) == gpmc_pkg::GPMC_STORE && mode_reg != gpmc_pkg::GPMC_STORE
      |-> mode_reg != gpmc_pkg::GPMC_RUN)
      else $error("storage exit skipped init");
   // a trip that still calls for sleep keeps the device asleep
   chk_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == gpmc_pkg::GPMC_TSLEEP && sleep_want && !wake_want && !store_armed
      && trips_i.above_por |=> mode_reg == gpmc_pkg::GPMC_TSLEEP)
      else $error("timed sleep left while requested");
   // reduced-rate bit moves run to reduced rate
   chk_rate_enter: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == gpmc_pkg::GPMC_RUN && rate_en_reg && !sleep_want && !store_armed
      && trips_i.above_por |=> mode_reg == gpmc_pkg::GPMC_RATE)
      else $error("reduced-rate not entered");
   // armed storage entry wins over run, reduced-rate and timed sleep
   chk_store_priority: assert property (@(posedge clk_i) disable iff (rst_i)
      store_armed && both_low && line_cnt_reg >= ENTRY_CYC - 1 && trips_i.above_por
      && (mode_reg == gpmc_pkg::GPMC_RUN || mode_reg == gpmc_pkg::GPMC_RATE
          || mode_reg == gpmc_pkg::GPMC_TSLEEP) |=> mode_reg == gpmc_pkg::GPMC_STORE)
      else $error("storage sleep lost priority");
   // analog circuits are powered for every conversion
   chk_conv_analog: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_start_o |-> analog_on_o)
      else $error("conversion with analog off");
endmodule : gpmc_ctrl

/* File: dv/gpmc_host_model.sv */
// host side model that holds or releases the two bus lines
`timescale 1ns/1ns
module gpmc_host_model (
   // clock
   input  wire logic clk_i,
   // request to hold both lines low
   input  wire logic hold_low_i,
   // line levels seen by the device
   output logic      scl_o,
   output logic      sda_o
);
   // released lines are pulled up, so idle and wake both show high;
   // both lines move together, low while holding, high once let go
   always @(posedge clk_i) begin
      scl_o <= ~hold_low_i;
      sda_o <= ~hold_low_i;
   end
endmodule : gpmc_host_model

/* File: dv/gauge_power_mode_controller_tb.sv */
// self-checking bench for the gauge power mode controller
`timescale 1ns/1ns
module gauge_power_mode_controller_tb;
   localparam int unsigned HALF = 20;            // shortened half second
   localparam int unsigned ENT  = 8;             // shortened storage entry time
   localparam int unsigned WAK  = 8;             // shortened wake time
   logic                  clk_i = 1'b0;          // core clock
   logic                  rst_i, cyc, stb, we, hold_low, scl, sda;
   logic [7:0]            adr;                   // bus address
   logic [31:0]           dat_w, dat_r, rd;      // bus data
   logic                  ack, nv_load, conv, tick, ana, osc, ign, sel_conv;
   logic [2:0]            mode;                  // reported mode
   logic [3:0]            sel = 4'h0;            // byte lanes on the bus
   logic [3:0]            lanes = 4'h1;          // byte lanes for the next access
   gpmc_pkg::gpmc_trips_t trips;                 // comparator levels
   int                    error_cnt = 0;         // mismatches
   int                    num_checks = 0;        // comparisons
   int                    cyc_cnt = 0;           // timeout counter
   int                    n;                     // measured gap
   wire                   probe = sel_conv ? conv : tick; // signal whose period is measured

   gpmc_ctrl #(.HALF_CYC(HALF), .ENTRY_CYC(ENT), .WAKE_CYC(WAK), .INIT_CYC(16)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .trips_i(trips),
      .scl_i(scl), .sda_i(sda), .nv_load_o(nv_load), .conv_start_o(conv), .accum_tick_o(tick),
      .analog_on_o(ana), .lp_osc_on_o(osc), .bus_ignore_o(ign), .mode_o(mode));
   gpmc_host_model host_u (.clk_i(clk_i), .hold_low_i(hold_low), .scl_o(scl), .sda_o(sda));

   // clock and hang guard
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // compare one result, values are zero-extended to a word
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp
   // one classic wishbone cycle, held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      sel   <= lanes;
      adr   <= a;
      dat_w <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   // wait a bounded time for a mode, then compare it
   task automatic wait_mode(input logic [2:0] m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++) @(posedge clk_i);
      cmp({29'h0, mode}, {29'h0, m}, "mode");
   endtask : wait_mode
   // cycles from one rise of the probe to the next
   task automatic gap(input logic c, output int k);
      sel_conv = c;
      while (probe !== 1'b0) @(posedge clk_i);
      while (probe !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      k = 1;
      while (probe === 1'b1) begin @(posedge clk_i); k++; end
      while (probe !== 1'b1) begin @(posedge clk_i); k++; end
   endtask : gap
   // counts and verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // main sequence
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat_w = 32'h0;
      trips = '0; hold_low = 1'b0; sel_conv = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      cmp({29'h0, mode}, 32'h0, "held in reset");
      cmp({31'h0, ign}, 32'h1, "bus ignored in reset");
      trips.above_por <= 1'b1;
      wait_mode(gpmc_pkg::GPMC_INIT, 6);
      cmp({31'h0, nv_load}, 32'h1, "defaults loading");
      wait_mode(gpmc_pkg::GPMC_RUN, 24);
      cmp({30'h0, conv, ana}, 32'h3, "run converts");
      gap(1'b0, n); cmp(n, HALF, "tick period");
      wb(1'b0, gpmc_pkg::OFS_STATUS, 32'h0); cmp(rd, 32'h2, "status run");
      wb(1'b0, 8'h40, 32'h0); cmp(rd, 32'h0, "unmapped read");
      $display("test power_on done");
      wb(1'b1, gpmc_pkg::OFS_CONV_CFG, 32'h11);
      wait_mode(gpmc_pkg::GPMC_RATE, 10);
      gap(1'b1, n); cmp(n, 2 * HALF, "reduced set period");
      gap(1'b0, n); cmp(n, HALF, "reduced tick period");
      lanes = 4'h2;
      wb(1'b1, gpmc_pkg::OFS_CONV_CFG, 32'h200);
      lanes = 4'h1;
      wb(1'b0, gpmc_pkg::OFS_CONV_CFG, 32'h0); cmp(rd, 32'h211, "conversions field");
      while (conv !== 1'b0) @(posedge clk_i);
      while (conv !== 1'b1) @(posedge clk_i);
      n = 0;
      while (conv === 1'b1) begin @(posedge clk_i); n++; end
      cmp(n, 3, "conversions per set");
      wb(1'b1, gpmc_pkg::OFS_MODE_CTRL, 32'h11);
      wait_mode(gpmc_pkg::GPMC_TSLEEP, 10);
      cmp({31'h0, osc}, 32'h1, "low power oscillator");
      gap(1'b1, n); cmp(n, 4 * HALF, "sleep set period");
      cmp({30'h0, conv, ana}, 32'h3, "analog on for set");
      gap(1'b0, n); cmp(n, HALF, "sleep tick period");
      repeat (4) @(posedge clk_i);
      cmp({30'h0, conv, ana}, 32'h0, "analog off between sets");
      wb(1'b1, gpmc_pkg::OFS_MODE_CTRL, 32'h0);
      wait_mode(gpmc_pkg::GPMC_RATE, 10);
      wb(1'b1, gpmc_pkg::OFS_CONV_CFG, 32'h0);
      wait_mode(gpmc_pkg::GPMC_RUN, 10);
      $display("test rate_and_sleep done");
      wb(1'b1, gpmc_pkg::OFS_TRIP_CTRL, 32'h11);
      trips.cell_low <= 1'b1;
      wait_mode(gpmc_pkg::GPMC_TSLEEP, 10);
      repeat (3) @(posedge clk_i);
      cmp({29'h0, mode}, 32'h4, "trip keeps sleep");
      trips.volt_wake <= 1'b1;
      wait_mode(gpmc_pkg::GPMC_RUN, 10);
      trips.cell_low  <= 1'b0;
      trips.volt_wake <= 1'b0;
      wb(1'b1, gpmc_pkg::OFS_TRIP_CTRL, 32'h0);
      $display("test trips done");
      wb(1'b1, gpmc_pkg::OFS_MODE_CTRL, 32'h2);
      hold_low <= 1'b1;
      repeat (4) @(posedge clk_i);
      cmp({29'h0, mode}, 32'h2, "early storage entry");
      wait_mode(gpmc_pkg::GPMC_STORE, ENT + 10);
      cmp({30'h0, ign, conv}, 32'h2, "storage quiet");
      n = 0;
      repeat (2 * HALF) begin @(posedge clk_i); n += tick + conv; end
      cmp(n, 0, "no activity in storage");
      hold_low <= 1'b0;
      wait_mode(gpmc_pkg::GPMC_INIT, WAK + 10);
      wait_mode(gpmc_pkg::GPMC_RUN, 24);
      wb(1'b0, gpmc_pkg::OFS_MODE_CTRL, 32'h0); cmp(rd, 32'h0, "defaults reloaded");
      wb(1'b0, gpmc_pkg::OFS_CONV_CFG, 32'h0); cmp(rd, 32'h0, "config reloaded");
      $display("test storage done");
      tally_and_finish();
   end
endmodule : gauge_power_mode_controller_tb
